// ---- rtl/pmid_regs.svh ----
// Purpose : Command codes, byte counts and field positions of the
//           identity command bank.
// Assumes : Included by bare name from every design file that needs it.
// Notes   : Definitions only.
`ifndef PMID_REGS_SVH
`define PMID_REGS_SVH

////////////////////////////////////////////////////////////////////////
// Command codes
`define PMID_CMD_MAKER_REV     8'h9B
`define PMID_CMD_CHIP_ID       8'hAD
`define PMID_CMD_SI_REV        8'hAE
`define PMID_CMD_SYS_CFG1      8'hD1

////////////////////////////////////////////////////////////////////////
// Block byte counts and transfer lengths
`define PMID_CHIP_ID_COUNT     8'h06
`define PMID_SI_REV_COUNT      8'h01
`define PMID_MAKER_REV_COUNT   8'h01
`define PMID_WRITE_LEN         3'h2
`define PMID_PAST_END_BYTE     8'hFF

////////////////////////////////////////////////////////////////////////
// Silicon revision byte fields
`define PMID_REV_RSVD_BIT      7
`define PMID_REV_PSV_MSB       6
`define PMID_REV_PSV_LSB       4
`define PMID_REV_DEV_MSB       3
`define PMID_REV_DEV_LSB       0
`define PMID_PSV_WIDTH         3

////////////////////////////////////////////////////////////////////////
// Pin synchroniser depth
`define PMID_SYNC_STAGES       2

`endif

// ---- rtl/pmid_pkg.sv ----
// Purpose : Shared types of the identity command bank.
// Assumes : Transaction kind is decoded by the PMBus link layer.
// Notes   : Enum order is the wire encoding of txn_op (0..3).
package pmid_pkg;

    typedef enum logic [1:0] {
        PMID_OP_WRITE_WORD,
        PMID_OP_READ_WORD,
        PMID_OP_BLOCK_WRITE,
        PMID_OP_BLOCK_READ
    } pmid_op_t;

    typedef enum logic [1:0] {
        PMID_IDLE,
        PMID_WRITE,
        PMID_READ,
        PMID_DRAIN
    } pmid_state_t;

endpackage : pmid_pkg

// ---- rtl/pmid_pin_sync.sv ----
// Purpose : Two-flop synchroniser for a group of pin levels.
// Assumes : Inputs are quasi-static levels from outside the clock domain.
// Notes   : Only the last stage is read outside this module.
`timescale 1ns/1ns
`include "pmid_regs.svh"

module pmid_pin_sync #(
    parameter int WIDTH  = `PMID_PSV_WIDTH,
    parameter int STAGES = `PMID_SYNC_STAGES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // Levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] stage;
    } pmid_sync_t;

    pmid_sync_t s_q;
    pmid_sync_t s_d;

    if (STAGES < 2 || WIDTH < 1)
    begin : g_bad_param
        $error("pmid_pin_sync: needs two stages and one bit");
    end

    always_comb
    begin
        s_d          = s_q;
        s_d.stage[0] = pin_in;
        for (int i = 1; i < STAGES; i++)
            s_d.stage[i] = s_q.stage[i-1];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign pin_sync = s_q.stage[STAGES-1];

endmodule : pmid_pin_sync

// ---- rtl/pmid_reply.sv ----
// Purpose : Selects the byte answered at a given position of a read.
// Assumes : Only supported read commands reach it.
// Notes   : Pure lookup; the caller registers the result.
`timescale 1ns/1ns
`include "pmid_regs.svh"

module pmid_reply (
    // Position in the read
    input  wire logic [7:0]  cmd,
    input  wire logic [2:0]  idx,
    // Sources
    input  wire logic [7:0]  maker_rev,
    input  wire logic [15:0] cfg_word,
    input  wire logic [7:0]  si_rev,
    input  wire logic [47:0] chip_id,
    // Answer
    output logic      [7:0]  reply_byte
);

    always_comb
    begin
        reply_byte = `PMID_PAST_END_BYTE;
        unique case (cmd)
            `PMID_CMD_CHIP_ID:
            begin
                // Count byte first, then the six bytes low byte first
                if (idx == 3'h0)
                    reply_byte = `PMID_CHIP_ID_COUNT;
                else if (idx <= 3'h6)
                    reply_byte = chip_id[8*(idx-3'h1) +: 8];
            end
            `PMID_CMD_SI_REV:
            begin
                if (idx == 3'h0)
                    reply_byte = `PMID_SI_REV_COUNT;
                else if (idx == 3'h1)
                    reply_byte = si_rev;
            end
            `PMID_CMD_MAKER_REV:
            begin
                if (idx == 3'h0)
                    reply_byte = `PMID_MAKER_REV_COUNT;
                else if (idx == 3'h1)
                    reply_byte = maker_rev;
            end
            `PMID_CMD_SYS_CFG1:
            begin
                // Word read: low byte, then high byte, no count
                if (idx == 3'h0)
                    reply_byte = cfg_word[7:0];
                else if (idx == 3'h1)
                    reply_byte = cfg_word[15:8];
            end
            default:
                reply_byte = `PMID_PAST_END_BYTE;
        endcase
    end

endmodule : pmid_reply

// ---- rtl/pmid_identity_bank.sv ----
// Purpose : Identity and configuration commands of a PMBus target port.
// Assumes : A same-clock PMBus link layer decodes each transaction.
// Notes   : Rules of the command bank follow.
// Operation
// - Command ADh answers block read only; any write is refused.
// - Identification block read announces and carries six data bytes.
// - First two identification bytes are the maker code, low byte first.
// - Bytes three to five hold part-number digits; byte six the extension.
// - Command AEh is a read-only block read with count one.
// - Revision bits 3:0 hold the fixed silicon revision number.
// - Revision bit 7 always reads zero.
// - Revision bits 6:4 show the power-stage die identification pins.
// - Command D1h takes a write word and answers a read word.
// - Maker revision byte is block written and read, and saved to NVM.
`timescale 1ns/1ns
`include "pmid_regs.svh"

module pmid_identity_bank #(
    // Arbitrary neutral values, not any real maker or part
    parameter logic [15:0] MAKER_CODE  = 16'h4B4D,
    parameter logic [23:0] PART_NUMBER = 24'h123456,
    parameter logic [7:0]  PART_EXT    = 8'h00,
    parameter logic [3:0]  DEV_REV     = 4'h0
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           ce,
    // Transaction from the link layer
    input  wire logic                           txn_start,
    input  wire logic [7:0]                     txn_cmd,
    input  wire pmid_pkg::pmid_op_t             txn_op,
    input  wire logic                           txn_stop,
    input  wire logic                           wr_valid,
    input  wire logic [7:0]                     wr_data,
    input  wire logic                           rd_req,
    // Answers to the link layer
    output logic                                rd_valid,
    output logic [7:0]                          rd_data,
    output logic                                txn_nack,
    // Nonvolatile store
    input  wire logic [7:0]                     nvm_rev_init,
    input  wire logic [15:0]                    nvm_cfg_init,
    output logic                                nvm_save_req,
    output logic [7:0]                          nvm_save_data,
    // Power-stage die identification pins
    input  wire logic [`PMID_PSV_WIDTH-1:0]     ps_die_id,
    // Configuration out
    output logic [15:0]                         system_config_word_one,
    output logic                                bank_ready
);

    import pmid_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        pmid_state_t state;
        logic [7:0]  cmd;
        logic [2:0]  idx;
        logic        wr_over;
        logic [7:0]  wbuf0;
        logic [7:0]  wbuf1;
        logic        loaded;
        logic [7:0]  maker_rev;
        logic [15:0] cfg_word;
        logic        rd_valid;
        logic [7:0]  rd_data;
        logic        nack;
        logic        save_req;
    } pmid_bank_t;

    pmid_bank_t                      s_q;
    pmid_bank_t                      s_d;
    logic [`PMID_PSV_WIDTH-1:0]      power_stage_version;
    logic [7:0]                      si_rev;
    logic [47:0]                     chip_id;
    logic [7:0]                      reply_byte;

    if (MAKER_CODE[7:0] < 8'h20 || MAKER_CODE[7:0] > 8'h7E ||
        MAKER_CODE[15:8] < 8'h20 || MAKER_CODE[15:8] > 8'h7E)
    begin : g_bad_maker
        $error("pmid_identity_bank: maker code must be ASCII");
    end

    ////////////////////////////////////////////////////////////////////
    // Constant answers and the pin-fed revision field

    pmid_pin_sync #(
        .WIDTH  (`PMID_PSV_WIDTH),
        .STAGES (`PMID_SYNC_STAGES)
    ) u_psv_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .pin_in   (ps_die_id),
        .pin_sync (power_stage_version)
    );

    always_comb
    begin
        si_rev = 8'h00;
        si_rev[`PMID_REV_RSVD_BIT] = 1'b0;
        si_rev[`PMID_REV_PSV_MSB:`PMID_REV_PSV_LSB]
            = power_stage_version;
        si_rev[`PMID_REV_DEV_MSB:`PMID_REV_DEV_LSB] = DEV_REV;
    end

    // Part digits go out first/second digit in the lowest byte
    assign chip_id = {PART_EXT, PART_NUMBER[7:0], PART_NUMBER[15:8],
                      PART_NUMBER[23:16], MAKER_CODE};

    pmid_reply u_reply (
        .cmd        (s_q.cmd),
        .idx        (s_q.idx),
        .maker_rev  (s_q.maker_rev),
        .cfg_word   (s_q.cfg_word),
        .si_rev     (si_rev),
        .chip_id    (chip_id),
        .reply_byte (reply_byte)
    );

    ////////////////////////////////////////////////////////////////////
    // Which command accepts which transaction

    function automatic logic op_ok(input logic [7:0] c,
                                   input pmid_op_t   o);
        logic ok;
        ok = 1'b0;
        unique case (c)
            `PMID_CMD_CHIP_ID,
            `PMID_CMD_SI_REV:
                ok = (o == PMID_OP_BLOCK_READ);
            `PMID_CMD_MAKER_REV:
                ok = (o == PMID_OP_BLOCK_READ) ||
                     (o == PMID_OP_BLOCK_WRITE);
            `PMID_CMD_SYS_CFG1:
                ok = (o == PMID_OP_READ_WORD) ||
                     (o == PMID_OP_WRITE_WORD);
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction : op_ok

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_d          = s_q;
        s_d.rd_valid = 1'b0;
        s_d.nack     = 1'b0;
        s_d.save_req = 1'b0;
        // NVM contents are taken once, after reset has been released
        if (!s_q.loaded)
        begin
            s_d.loaded    = 1'b1;
            s_d.maker_rev = nvm_rev_init;
            s_d.cfg_word  = nvm_cfg_init;
        end
        if (txn_start)
        begin
            // A repeated start abandons whatever was in progress
            s_d.cmd     = txn_cmd;
            s_d.idx     = 3'h0;
            s_d.wr_over = 1'b0;
            if (!op_ok(txn_cmd, txn_op))
            begin
                s_d.nack  = 1'b1;
                s_d.state = PMID_DRAIN;
            end
            else if (txn_op == PMID_OP_BLOCK_READ ||
                     txn_op == PMID_OP_READ_WORD)
                s_d.state = PMID_READ;
            else
                s_d.state = PMID_WRITE;
        end
        else
        begin
            unique case (s_q.state)
                PMID_IDLE:
                    s_d.state = PMID_IDLE;
                PMID_WRITE:
                begin
                    if (wr_valid)
                    begin
                        if (s_q.idx == 3'h0)
                            s_d.wbuf0 = wr_data;
                        else if (s_q.idx == 3'h1)
                            s_d.wbuf1 = wr_data;
                        else
                            s_d.wr_over = 1'b1;
                        if (s_q.idx != 3'h7)
                            s_d.idx = 3'(s_q.idx + 3'h1);
                    end
                    if (txn_stop)
                    begin
                        s_d.state = PMID_IDLE;
                        if (s_q.wr_over || s_q.idx != `PMID_WRITE_LEN)
                            s_d.nack = 1'b1;
                        else if (s_q.cmd == `PMID_CMD_SYS_CFG1)
                            s_d.cfg_word = {s_q.wbuf1, s_q.wbuf0};
                        else if (s_q.wbuf0 == `PMID_MAKER_REV_COUNT)
                        begin
                            s_d.maker_rev = s_q.wbuf1;
                            s_d.save_req  = 1'b1;
                        end
                        else
                            s_d.nack = 1'b1;
                    end
                end
                PMID_READ:
                begin
                    if (rd_req)
                    begin
                        s_d.rd_valid = 1'b1;
                        s_d.rd_data  = reply_byte;
                        if (s_q.idx != 3'h7)
                            s_d.idx = 3'(s_q.idx + 3'h1);
                    end
                    if (txn_stop)
                        s_d.state = PMID_IDLE;
                end
                PMID_DRAIN:
                begin
                    // Refused transaction: bytes are dropped until stop
                    if (txn_stop)
                        s_d.state = PMID_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q          <= '0;
            s_q.state    <= PMID_IDLE;
            s_q.rd_data  <= `PMID_PAST_END_BYTE;
        end
        else if (ce)
            s_q <= s_d;
    end

    assign rd_valid               = s_q.rd_valid;
    assign rd_data                = s_q.rd_data;
    assign txn_nack               = s_q.nack;
    assign nvm_save_req           = s_q.save_req;
    assign nvm_save_data          = s_q.maker_rev;
    assign system_config_word_one = s_q.cfg_word;
    assign bank_ready             = s_q.loaded;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    logic rd_take;
    logic wr_end;
    assign rd_take = ce && !txn_start && s_q.state == PMID_READ && rd_req;
    assign wr_end  = ce && !txn_start && s_q.state == PMID_WRITE &&
                     txn_stop && !s_q.wr_over &&
                     s_q.idx == `PMID_WRITE_LEN;

    AST_CHIP_ID_NO_WRITE: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce && txn_start && txn_cmd == `PMID_CMD_CHIP_ID &&
        txn_op != PMID_OP_BLOCK_READ |=> txn_nack && !rd_valid)
        else $error("write to chip id not refused");

    AST_CHIP_ID_COUNT: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_CHIP_ID && s_q.idx == 3'h0
        |=> rd_valid && rd_data == `PMID_CHIP_ID_COUNT)
        else $error("chip id count byte is not six");

    AST_MAKER_LSB_FIRST: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_CHIP_ID &&
        (s_q.idx == 3'h1 || s_q.idx == 3'h2) |=> rd_data ==
        ($past(s_q.idx) == 3'h1 ? MAKER_CODE[7:0] : MAKER_CODE[15:8]))
        else $error("maker code bytes out of order");

    AST_PART_DIGITS: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_CHIP_ID && s_q.idx == 3'h3
        |=> rd_data == PART_NUMBER[23:16])
        else $error("first part digits wrong");

    AST_SI_REV_COUNT: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_SI_REV && s_q.idx == 3'h0
        |=> rd_data == `PMID_SI_REV_COUNT)
        else $error("revision count byte is not one");

    AST_DEV_REV_FIELD: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_SI_REV && s_q.idx == 3'h1
        |=> rd_data[`PMID_REV_DEV_MSB:`PMID_REV_DEV_LSB] == DEV_REV)
        else $error("device revision field wrong");

    AST_RSVD_ZERO: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_SI_REV && s_q.idx == 3'h1
        |=> !rd_data[`PMID_REV_RSVD_BIT])
        else $error("reserved revision bit set");

    AST_PSV_FROM_PIN: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_SI_REV && s_q.idx == 3'h1
        |=> rd_data[`PMID_REV_PSV_MSB:`PMID_REV_PSV_LSB] ==
        $past(power_stage_version))
        else $error("power stage field not from pins");

    AST_CFG_WRITE: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_end && s_q.cmd == `PMID_CMD_SYS_CFG1 |=>
        system_config_word_one == {$past(s_q.wbuf1), $past(s_q.wbuf0)}
        && !txn_nack)
        else $error("config word write lost");

    AST_MAKER_SAVE: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_end && s_q.cmd == `PMID_CMD_MAKER_REV &&
        s_q.wbuf0 == `PMID_MAKER_REV_COUNT |=> nvm_save_req &&
        nvm_save_data == $past(s_q.wbuf1))
        else $error("maker revision not saved");

    AST_MAKER_READBACK: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_MAKER_REV && s_q.idx == 3'h1
        |=> rd_data == nvm_save_data)
        else $error("maker revision read back wrong");

    COV_CHIP_ID_EXT: cover property (
        @(posedge clk) disable iff (sys_rst)
        rd_take && s_q.cmd == `PMID_CMD_CHIP_ID && s_q.idx == 3'h6);

    COV_MAKER_SAVE: cover property (
        @(posedge clk) disable iff (sys_rst) nvm_save_req);

    COV_REFUSED: cover property (
        @(posedge clk) disable iff (sys_rst) txn_nack);

endmodule : pmid_identity_bank

// ---- verif/pmid_host_model.sv ----
// Purpose : Host side of the PMBus link layer, issuing transactions.
// Assumes : Requests change only by non-blocking assignment at rising clk.
// Notes   : A released data byte shows its inverse, never a stale copy.
`timescale 1ns/1ns

module pmid_host_model (
    // Clock
    input  wire logic          clk,
    // Requests
    output logic               txn_start,
    output logic [7:0]         txn_cmd,
    output pmid_pkg::pmid_op_t txn_op,
    output logic               txn_stop,
    output logic               wr_valid,
    output logic [7:0]         wr_data,
    output logic               rd_req,
    // Answers
    input  wire logic          rd_valid,
    input  wire logic [7:0]    rd_data,
    input  wire logic          txn_nack,
    input  wire logic          nvm_save_req
);
    import pmid_pkg::*;

    logic [7:0] got;
    logic       valid_seen;
    logic       nack_seen;
    logic       save_seen;

    initial
    begin
        txn_start = 1'b0;
        txn_cmd   = 8'h00;
        txn_op    = PMID_OP_WRITE_WORD;
        txn_stop  = 1'b0;
        wr_valid  = 1'b0;
        wr_data   = 8'h00;
        rd_req    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Each answer is one cycle wide, so it is sampled just after the
    // edge that follows the request
    task automatic open_txn(input logic [7:0] c, input pmid_op_t o);
        @(posedge clk);
        txn_start <= 1'b1;
        txn_cmd   <= c;
        txn_op    <= o;
        @(posedge clk);
        txn_start <= 1'b0;
        txn_cmd   <= ~c;
        #1 nack_seen = txn_nack;
    endtask : open_txn

    task automatic put_byte(input logic [7:0] b);
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data  <= b;
        @(posedge clk);
        wr_valid <= 1'b0;
        wr_data  <= ~b;
    endtask : put_byte

    task automatic get_byte();
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        #1 valid_seen = rd_valid;
        got = rd_data;
    endtask : get_byte

    task automatic close_txn();
        @(posedge clk);
        txn_stop <= 1'b1;
        @(posedge clk);
        txn_stop <= 1'b0;
        #1 nack_seen = txn_nack;
        save_seen = nvm_save_req;
    endtask : close_txn

endmodule : pmid_host_model

// ---- verif/pmid_identity_bank_tb.sv ----
// Purpose : Self-checking bench of the identity command bank.
// Assumes : Host model drives transactions; bench drives pins and NVM.
// Notes   : Nonzero identity parameters catch stuck-at-zero fields.
`timescale 1ns/1ns

module pmid_identity_bank_tb;
    import pmid_pkg::*;

    // Arbitrary values, not any real maker or part
    localparam logic [15:0] MK = 16'h4B4D;
    localparam logic [23:0] PN = 24'h123456;
    localparam logic [7:0]  PX = 8'h7E;
    localparam logic [3:0]  DR = 4'h5;

    logic        clk, sys_rst, ce, txn_start, txn_stop, wr_valid, rd_req;
    logic        rd_valid, txn_nack, nvm_save_req, bank_ready;
    logic [7:0]  txn_cmd, wr_data, rd_data, nvm_rev_init, nvm_save_data;
    logic [15:0] nvm_cfg_init, system_config_word_one;
    logic [2:0]  ps_die_id;
    pmid_op_t    txn_op;
    int          err_count, n_checks, cycles;
    logic [7:0]  id_exp [8] = '{8'h06, MK[7:0], MK[15:8], PN[23:16],
                                PN[15:8], PN[7:0], PX, 8'hFF};
    logic [7:0]  bad_cmd [7] = '{8'hAD, 8'hAD, 8'hAE, 8'hAD, 8'hD1,
                                 8'h9B, 8'h00};
    pmid_op_t    bad_op [7] = '{PMID_OP_BLOCK_WRITE, PMID_OP_WRITE_WORD,
                                PMID_OP_BLOCK_WRITE, PMID_OP_READ_WORD,
                                PMID_OP_BLOCK_READ, PMID_OP_READ_WORD,
                                PMID_OP_BLOCK_READ};

    pmid_host_model i_host (.clk(clk), .txn_start(txn_start),
        .txn_cmd(txn_cmd), .txn_op(txn_op), .txn_stop(txn_stop),
        .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
        .rd_valid(rd_valid), .rd_data(rd_data), .txn_nack(txn_nack),
        .nvm_save_req(nvm_save_req));

    pmid_identity_bank #(.MAKER_CODE(MK), .PART_NUMBER(PN),
        .PART_EXT(PX), .DEV_REV(DR)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .ce(ce), .txn_start(txn_start), .txn_cmd(txn_cmd),
        .txn_op(txn_op), .txn_stop(txn_stop), .wr_valid(wr_valid),
        .wr_data(wr_data), .rd_req(rd_req), .rd_valid(rd_valid),
        .rd_data(rd_data), .txn_nack(txn_nack),
        .nvm_rev_init(nvm_rev_init), .nvm_cfg_init(nvm_cfg_init),
        .nvm_save_req(nvm_save_req), .nvm_save_data(nvm_save_data),
        .ps_die_id(ps_die_id),
        .system_config_word_one(system_config_word_one),
        .bank_ready(bank_ready));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] exp);
        i_host.get_byte();
        chk({7'h00, i_host.valid_seen, i_host.got}, {8'h01, exp});
    endtask : rd_chk

    task automatic wr2(input logic [7:0] c, input pmid_op_t o,
                       input logic [7:0] a, input logic [7:0] b);
        i_host.open_txn(c, o);
        i_host.put_byte(a);
        i_host.put_byte(b);
        i_host.close_txn();
    endtask : wr2

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge clk);
            cycles++;
            if (cycles == 5000)
            begin
                err_count++;
                report_and_stop();
            end
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        ps_die_id = 3'h0;
        nvm_rev_init = 8'h3C;
        nvm_cfg_init = 16'hA55A;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({15'h0000, bank_ready}, 16'h0001);
        chk(system_config_word_one, 16'hA55A);
        chk({8'h00, nvm_save_data}, 16'h003C);
        i_host.open_txn(8'hAD, PMID_OP_BLOCK_READ);
        foreach (id_exp[i]) rd_chk(id_exp[i]);
        i_host.close_txn();
        for (int p = 0; p < 8; p++)
        begin
            @(posedge clk);
            ps_die_id <= p[2:0];
            repeat (3) @(posedge clk);
            i_host.open_txn(8'hAE, PMID_OP_BLOCK_READ);
            rd_chk(8'h01);
            rd_chk({1'b0, p[2:0], DR});
            i_host.close_txn();
        end
        // Refused pairs must not answer any read byte
        for (int k = 0; k < 7; k++)
        begin
            i_host.open_txn(bad_cmd[k], bad_op[k]);
            chk({15'h0000, i_host.nack_seen}, 16'h0001);
            i_host.get_byte();
            chk({15'h0000, i_host.valid_seen}, 16'h0000);
            i_host.close_txn();
        end
        wr2(8'hD1, PMID_OP_WRITE_WORD, 8'h34, 8'h12);
        chk({15'h0000, i_host.nack_seen}, 16'h0000);
        chk({15'h0000, i_host.save_seen}, 16'h0000);
        chk(system_config_word_one, 16'h1234);
        i_host.open_txn(8'hD1, PMID_OP_READ_WORD);
        rd_chk(8'h34);
        rd_chk(8'h12);
        i_host.close_txn();
        // A one-byte word write is malformed and leaves the word alone
        i_host.open_txn(8'hD1, PMID_OP_WRITE_WORD);
        i_host.put_byte(8'hFF);
        i_host.close_txn();
        chk({15'h0000, i_host.nack_seen}, 16'h0001);
        chk(system_config_word_one, 16'h1234);
        // Three bytes overrun the word and leave it alone
        i_host.open_txn(8'hD1, PMID_OP_WRITE_WORD);
        i_host.put_byte(8'hAA);
        i_host.put_byte(8'hBB);
        i_host.put_byte(8'hCC);
        i_host.close_txn();
        chk({15'h0000, i_host.nack_seen}, 16'h0001);
        chk(system_config_word_one, 16'h1234);
        i_host.open_txn(8'h9B, PMID_OP_BLOCK_READ);
        rd_chk(8'h01);
        rd_chk(8'h3C);
        i_host.close_txn();
        wr2(8'h9B, PMID_OP_BLOCK_WRITE, 8'h01, 8'hC7);
        chk({15'h0000, i_host.save_seen}, 16'h0001);
        chk({8'h00, nvm_save_data}, 16'h00C7);
        // Wrong count byte is refused and keeps the stored value
        wr2(8'h9B, PMID_OP_BLOCK_WRITE, 8'h02, 8'h55);
        chk({15'h0000, i_host.nack_seen}, 16'h0001);
        chk({15'h0000, i_host.save_seen}, 16'h0000);
        chk({8'h00, nvm_save_data}, 16'h00C7);
        i_host.open_txn(8'h9B, PMID_OP_BLOCK_READ);
        // A read byte asked for while ce is low is not taken
        @(posedge clk);
        ce <= 1'b0;
        i_host.get_byte();
        chk({15'h0000, i_host.valid_seen}, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(8'h01);
        rd_chk(8'hC7);
        i_host.close_txn();
        // Reset in mid-run takes the stored NVM values again
        @(posedge clk);
        sys_rst      <= 1'b1;
        nvm_rev_init <= 8'h96;
        repeat (2) @(posedge clk);
        #1 chk({7'h00, bank_ready, rd_data}, 16'h00FF);
        chk(system_config_word_one, 16'h0000);
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({8'h00, nvm_save_data}, 16'h0096);
        chk(system_config_word_one, 16'hA55A);
        i_host.open_txn(8'h9B, PMID_OP_BLOCK_READ);
        rd_chk(8'h01);
        rd_chk(8'h96);
        i_host.close_txn();
        report_and_stop();
    end

endmodule : pmid_identity_bank_tb
